// ### design/pwt_defs.vh
// register map, field positions and reset values of the pwm timer channel 0 block
`ifndef PWT_DEFS_VH
`define PWT_DEFS_VH
`define PWT_ADDR_W 8
`define PWT_OFF_STATUS 8'h00
`define PWT_OFF_IRQ_REQ 8'h04
`define PWT_OFF_IRQ_MASK 8'h08
`define PWT_OFF_START 8'h0c
`define PWT_OFF_GRA0 8'h10
`define PWT_OFF_GRA1 8'h14
`define PWT_OFF_GRB0 8'h18
`define PWT_OFF_GRB1 8'h1c
`define PWT_OFF_GRC0 8'h20
`define PWT_OFF_GRC1 8'h24
`define PWT_OFF_GRD0 8'h28
`define PWT_OFF_GRD1 8'h2c
`define PWT_OFF_CTRL 8'h30
`define PWT_OFF_COUNT 8'h34
`define PWT_OFF_EVT 8'h38
`define PWT_OFF_EVT_EN 8'h3c
`define PWT_ST_MFA 0
`define PWT_ST_MFB 1
`define PWT_ST_MFC 2
`define PWT_ST_MFD 3
`define PWT_ST_OVF 4
`define PWT_IRQ_CH0 1
`define PWT_RUN_CH0 0
`define PWT_RUN_CH1 1
`define PWT_CTRL_BUF 0
`define PWT_CTRL_MFA_IE 1
`define PWT_RST_STATUS 5'h00
`define PWT_RST_IRQ_REQ 8'h00
`define PWT_RST_IRQ_MASK 8'hff
`define PWT_RST_START 4'h0
`define PWT_RST_CTRL 2'h2
`define PWT_RST_GR 16'hffff
`define PWT_RST_EVT_EN 5'h00
`define PWT_RESP_OKAY 2'b00
`define PWT_RESP_SLVERR 2'b10
`endif

// ### design/pwt_top.v
// pwm timer channel 0: count start, compare match flags, interrupt request, axi4-lite slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
`include "pwt_defs.vh"

// Behaviour
// - counter equals period register sets flag A
// - flag A clears by 0 after read
// - status: ovf bit4, flags D..A bits3..0
// - request flag bit1 shows pending request
// - mask bit1: 0 enables, 1 disables
// - start bit0 runs ch0, bit1 ch1
// - period register match ends each period
// - A1, B1 set outputs; B0 returns B
// - buffers C/D reload registers each period
module pwt_top (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg pwm_out_a,
    output reg pwm_out_b,
    output reg ch0_interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a[1:0] == 2'b00) && (a <= `PWT_OFF_EVT_EN);
        end
    endfunction

    // byte-lane merge for the 16-bit general registers
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] d;
        input [3:0] s;
        begin
            merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    // one register strobe: a taken beat aimed at one word offset
    function reg_hit;
        input go;
        input [7:0] a;
        input [7:0] off;
        begin
            reg_hit = go && (a == off);
        end
    endfunction

    // compare match shared by every general register except GRC1 and GRD1, and the overflow check
    function cmp_hit;
        input run;
        input [15:0] cnt;
        input [15:0] gr;
        begin
            cmp_hit = run && (cnt == gr);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state
    reg [4:0] ch0_status_reg_ff;
    reg [4:0] clr_armed_ff;
    reg [7:0] irq_request_reg_2h_ff;
    reg [7:0] irq_mask_reg_2h_ff;
    reg [3:0] count_start_reg_ff;
    reg [1:0] ctrl_ff;
    reg [4:0] evt_ff;
    reg [4:0] evt_en_ff;
    reg [15:0] period_reg_ff;
    reg [15:0] out_a_set_point_ff;
    reg [15:0] out_b_return_point_ff;
    reg [15:0] out_b_set_point_ff;
    reg [15:0] next_period_buffer_ff;
    reg [15:0] next_a_set_ff;
    reg [15:0] next_b_return_ff;
    reg [15:0] next_b_set_ff;
    reg [15:0] ch0_counter_ff;

    // bus channel state
    reg [7:0] aw_addr_ff;
    reg aw_got_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg w_got_ff;

    ////////////////////////////////////////////////////////////////////////////
    // write address and data are taken in either order, answered once both are in
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire [7:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr_ff;
    wire [31:0] wr_data = w_take ? s_axi_wdata : w_data_ff;
    wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb_ff;
    wire wr_go = (aw_take | aw_got_ff) & (w_take | w_got_ff) & ~s_axi_bvalid;
    wire wr_ok = wr_go & is_mapped(wr_addr);
    wire wr_lo = wr_ok & wr_strb[0];
    wire rd_go = s_axi_arvalid & s_axi_arready;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PWT_RESP_OKAY;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (ce) begin
            if (aw_take) begin
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(wr_addr) ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
            end else begin
                aw_got_ff <= aw_got_ff | aw_take;
                w_got_ff <= w_got_ff | w_take;
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
            // ready one cycle after reset and after each accepted beat is retired
            s_axi_awready <= ~(aw_got_ff | aw_take) & ~wr_go & ~s_axi_bvalid;
            s_axi_wready <= ~(w_got_ff | w_take) & ~wr_go & ~s_axi_bvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel: one read in flight, rdata latched when the address is taken
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            `PWT_OFF_STATUS: rd_val = {27'h0, ch0_status_reg_ff};
            `PWT_OFF_IRQ_REQ: rd_val = {24'h0, irq_request_reg_2h_ff};
            `PWT_OFF_IRQ_MASK: rd_val = {24'h0, irq_mask_reg_2h_ff};
            `PWT_OFF_START: rd_val = {28'h0, count_start_reg_ff};
            `PWT_OFF_GRA0: rd_val = {16'h0, period_reg_ff};
            `PWT_OFF_GRA1: rd_val = {16'h0, out_a_set_point_ff};
            `PWT_OFF_GRB0: rd_val = {16'h0, out_b_return_point_ff};
            `PWT_OFF_GRB1: rd_val = {16'h0, out_b_set_point_ff};
            `PWT_OFF_GRC0: rd_val = {16'h0, next_period_buffer_ff};
            `PWT_OFF_GRC1: rd_val = {16'h0, next_a_set_ff};
            `PWT_OFF_GRD0: rd_val = {16'h0, next_b_return_ff};
            `PWT_OFF_GRD1: rd_val = {16'h0, next_b_set_ff};
            `PWT_OFF_CTRL: rd_val = {30'h0, ctrl_ff};
            `PWT_OFF_COUNT: rd_val = {16'h0, ch0_counter_ff};
            `PWT_OFF_EVT: rd_val = {27'h0, evt_ff};
            `PWT_OFF_EVT_EN: rd_val = {27'h0, evt_en_ff};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PWT_RESP_OKAY;
        end else if (ce) begin
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? `PWT_RESP_OKAY : `PWT_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            // held high while idle, so an address is never left waiting on a toggle
            if (rd_go || s_axi_rvalid) begin
                s_axi_arready <= 1'b0;
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter and compare events
    wire ch0_run = count_start_reg_ff[`PWT_RUN_CH0];
    wire buf_sel = ctrl_ff[`PWT_CTRL_BUF];
    wire tick = ch0_run;
    wire hit_a = cmp_hit(tick, ch0_counter_ff, period_reg_ff);
    wire hit_b = cmp_hit(tick, ch0_counter_ff, out_b_return_point_ff);
    wire set_a = cmp_hit(tick, ch0_counter_ff, out_a_set_point_ff);
    wire set_b = cmp_hit(tick, ch0_counter_ff, out_b_set_point_ff);
    // c and d registers only compare when they are not serving as buffers
    wire hit_c = cmp_hit(tick && !buf_sel, ch0_counter_ff, next_period_buffer_ff);
    wire hit_d = cmp_hit(tick && !buf_sel, ch0_counter_ff, next_b_return_ff);
    wire hit_ovf = cmp_hit(tick && !hit_a, ch0_counter_ff, 16'hffff);
    wire [4:0] st_set = {hit_ovf, hit_d, hit_c, hit_b, hit_a};
    wire req_set = hit_a & ctrl_ff[`PWT_CTRL_MFA_IE];

    always @(posedge aclk) begin
        if (!aresetn) begin
            ch0_counter_ff <= 16'h0000;
            pwm_out_a <= 1'b0;
            pwm_out_b <= 1'b0;
        end else if (ce && tick) begin
            if (hit_a) begin
                ch0_counter_ff <= 16'h0000;
                pwm_out_a <= 1'b0;
                pwm_out_b <= 1'b0;
            end else begin
                ch0_counter_ff <= ch0_counter_ff + 16'h0001;
                if (set_a) begin
                    pwm_out_a <= 1'b1;
                end
                if (hit_b) begin
                    pwm_out_b <= 1'b0;
                end else if (set_b) begin
                    pwm_out_b <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-visible registers; hardware sets always win over a clear in the same cycle
    wire st_wr = reg_hit(wr_lo, wr_addr, `PWT_OFF_STATUS);
    wire st_rd = reg_hit(rd_go, s_axi_araddr, `PWT_OFF_STATUS);
    wire [4:0] st_clr = {5{st_wr}} & ~wr_data[4:0] & clr_armed_ff;
    wire rq_wr = reg_hit(wr_lo, wr_addr, `PWT_OFF_IRQ_REQ);
    wire mk_wr = reg_hit(wr_lo, wr_addr, `PWT_OFF_IRQ_MASK);
    wire run_wr = reg_hit(wr_lo, wr_addr, `PWT_OFF_START);
    wire ctl_wr = reg_hit(wr_lo, wr_addr, `PWT_OFF_CTRL);
    wire een_wr = reg_hit(wr_lo, wr_addr, `PWT_OFF_EVT_EN);
    wire ev_wr = reg_hit(wr_lo, wr_addr, `PWT_OFF_EVT);
    wire [4:0] ev_clr = {5{ev_wr}} & wr_data[4:0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            ch0_status_reg_ff <= `PWT_RST_STATUS;
            clr_armed_ff <= 5'h00;
            irq_request_reg_2h_ff <= `PWT_RST_IRQ_REQ;
            irq_mask_reg_2h_ff <= `PWT_RST_IRQ_MASK;
            count_start_reg_ff <= `PWT_RST_START;
            ctrl_ff <= `PWT_RST_CTRL;
            evt_ff <= 5'h00;
            evt_en_ff <= `PWT_RST_EVT_EN;
            ch0_interrupt <= 1'b0;
        end else if (ce) begin
            ch0_status_reg_ff <= (ch0_status_reg_ff & ~st_clr) | st_set;
            // a read arms the clear only for bits seen as 1; a status write with byte lane 0 disarms, unless a status read is taken in the same cycle
            if (st_rd) begin
                clr_armed_ff <= ch0_status_reg_ff;
            end else if (st_wr) begin
                clr_armed_ff <= 5'h00;
            end
            if (rq_wr) begin
                irq_request_reg_2h_ff <= wr_data[7:0];
            end
            if (req_set) begin
                irq_request_reg_2h_ff[`PWT_IRQ_CH0] <= 1'b1;
            end
            if (mk_wr) begin
                irq_mask_reg_2h_ff <= wr_data[7:0];
            end
            if (run_wr) begin
                count_start_reg_ff <= wr_data[3:0];
            end
            if (ctl_wr) begin
                ctrl_ff <= wr_data[1:0];
            end
            if (een_wr) begin
                evt_en_ff <= wr_data[4:0];
            end
            evt_ff <= (evt_ff & ~ev_clr) | st_set;
            // request path is held off by the mask bit, event path by its enable
            ch0_interrupt <= (irq_request_reg_2h_ff[`PWT_IRQ_CH0]
                              & ~irq_mask_reg_2h_ff[`PWT_IRQ_CH0])
                             | (|(evt_ff & evt_en_ff));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // general and buffer registers; buffer reload at period end beats a same-cycle write
    always @(posedge aclk) begin
        if (!aresetn) begin
            period_reg_ff <= `PWT_RST_GR;
            out_a_set_point_ff <= `PWT_RST_GR;
            out_b_return_point_ff <= `PWT_RST_GR;
            out_b_set_point_ff <= `PWT_RST_GR;
            next_period_buffer_ff <= `PWT_RST_GR;
            next_a_set_ff <= `PWT_RST_GR;
            next_b_return_ff <= `PWT_RST_GR;
            next_b_set_ff <= `PWT_RST_GR;
        end else if (ce) begin
            if (wr_ok) begin
                case (wr_addr)
                    `PWT_OFF_GRA0: period_reg_ff <= merge16(period_reg_ff, wr_data, wr_strb);
                    `PWT_OFF_GRA1:
                        out_a_set_point_ff <= merge16(out_a_set_point_ff, wr_data, wr_strb);
                    `PWT_OFF_GRB0:
                        out_b_return_point_ff <= merge16(out_b_return_point_ff, wr_data, wr_strb);
                    `PWT_OFF_GRB1:
                        out_b_set_point_ff <= merge16(out_b_set_point_ff, wr_data, wr_strb);
                    `PWT_OFF_GRC0:
                        next_period_buffer_ff <= merge16(next_period_buffer_ff, wr_data, wr_strb);
                    `PWT_OFF_GRC1: next_a_set_ff <= merge16(next_a_set_ff, wr_data, wr_strb);
                    `PWT_OFF_GRD0: next_b_return_ff <= merge16(next_b_return_ff, wr_data, wr_strb);
                    `PWT_OFF_GRD1: next_b_set_ff <= merge16(next_b_set_ff, wr_data, wr_strb);
                    default: ;
                endcase
            end
            if (hit_a && buf_sel) begin
                period_reg_ff <= next_period_buffer_ff;
                out_a_set_point_ff <= next_a_set_ff;
                out_b_return_point_ff <= next_b_return_ff;
                out_b_set_point_ff <= next_b_set_ff;
            end
        end
    end

endmodule // pwt_top
`default_nettype wire

// ### tb/pwt_top_sva.sv
// assertion checker for the pwm timer channel 0 register bus and interrupt
`default_nettype none
`include "pwt_defs.vh"
module pwt_top_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ch0_interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mask_ff, quiet_ff, bad_ff;
    wire logic wr_hs = ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the mask bit; only writes whose address and data go in together are seen
    always_ff @(posedge aclk) begin
        if (ce && s_axi_arvalid && s_axi_arready)
            bad_ff <= s_axi_araddr > 8'h3c || s_axi_araddr[1:0] != 2'h0;
        if (!aresetn) begin
            mask_ff <= 1'b1;
            quiet_ff <= 1'b1;
        end else if (wr_hs) begin
            if (s_axi_awaddr == `PWT_OFF_IRQ_MASK)
                mask_ff <= s_axi_wdata[1];
            if (s_axi_awaddr == `PWT_OFF_EVT_EN)
                quiet_ff <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_rst_quiet; disable iff (1'b0) !aresetn && ce |=> !s_axi_bvalid && !ch0_interrupt;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("active after reset");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_b_after; wr_hs |=> s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("write response late");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
    property p_aw_block; s_axi_bvalid |-> !(s_axi_awready || s_axi_wready);
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
    property p_rresp; $rose(s_axi_rvalid) |-> (!bad_ff || s_axi_rdata == 32'h0)
        && s_axi_rresp == (bad_ff ? `PWT_RESP_SLVERR : `PWT_RESP_OKAY);
    endproperty
    a_rresp: assert property (p_rresp) else $error("read decode wrong");
    // four cycles leave room for the write commit and the registered output
    property p_masked; (quiet_ff && mask_ff)[*4] |-> !ch0_interrupt;
    endproperty
    a_masked: assert property (p_masked) else $error("masked interrupt seen");
endmodule // pwt_top_sva
`default_nettype wire

// ### tb/test_pwm_timer_start_and_match_irq.sv
// self-checking bench for the pwm timer channel 0 block
`default_nettype none
`include "pwt_defs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %0h want %0h", $time, (a), (e)); end end
module test_pwm_timer_start_and_match_irq;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, pwm_out_a, pwm_out_b, ch0_interrupt;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat, q;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int err_total = 0, tests_run = 0, seed = 68, p, b0, c;
    int ra[$] = '{0, 4, 8, 12, 16, 48, 52, 64, 2};
    int rv[$] = '{0, 0, 255, 0, 65535, 2, 0, 0, 0};
    always #25 aclk = ~aclk;
    pwt_top dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pwm_out_a, .pwm_out_b, .ch0_interrupt);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad = 0, wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(ad && wd && s_axi_bvalid));
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && !s_axi_arvalid));
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // counts cycles in c until the chosen output reaches v
    task automatic wt(input logic [1:0] s, input logic v);
        while ((s == 2 ? ch0_interrupt : s[0] ? pwm_out_b : pwm_out_a) !== v) begin
            @(posedge aclk);
            c++;
        end
    endtask
    task automatic per();
        wt(0, 0);
        wt(0, 1);
        c = 0;
        wt(0, 0);
        wt(0, 1);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(20000 * 50);
        err_total++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        p = 6 + ($unsigned($random(seed)) % 8);
        b0 = 2 + ($unsigned($random(seed)) % 4);
        foreach (ra[i]) begin
            rd(ra[i][7:0]);
            `CHK(rdat, 32'(rv[i]))
            `CHK(rsp, i > 6 ? `PWT_RESP_SLVERR : `PWT_RESP_OKAY)
        end
        wr(8'h40, 32'h1);
        `CHK(rsp, `PWT_RESP_SLVERR)
        $display("test reset_map done");
        rd(`PWT_OFF_STATUS);
        wr(`PWT_OFF_STATUS, 32'h0);
        wr(`PWT_OFF_IRQ_REQ, 32'h0);
        wr(`PWT_OFF_IRQ_MASK, 32'hfd);
        wr(`PWT_OFF_GRA0, p);
        wr(`PWT_OFF_GRA1, 32'h1);
        wr(`PWT_OFF_GRB1, 32'h1);
        wr(`PWT_OFF_GRB0, b0);
        wr(`PWT_OFF_START, 32'h1);
        c = 0;
        wt(2, 1);
        `CHK(c <= p + 8, 1'b1)
        rd(`PWT_OFF_STATUS);
        `CHK(rdat[0], 1'b1)
        rd(`PWT_OFF_IRQ_REQ);
        `CHK(rdat[1], 1'b1)
        per();
        `CHK(c, p + 1)
        c = 0;
        wt(1, 0);
        wt(1, 1);
        c = 0;
        wt(1, 0);
        `CHK(c, b0 - 1)
        // clock enable low: the running outputs must hold for longer than a period
        ce <= 1'b0;
        @(posedge aclk);
        q = {30'h0, pwm_out_a, pwm_out_b};
        repeat (p + 2) @(posedge aclk);
        rdat = {30'h0, pwm_out_a, pwm_out_b};
        `CHK(rdat, q)
        ce <= 1'b1;
        $display("test start_sequence done");
        wr(`PWT_OFF_START, 32'h2);
        rd(`PWT_OFF_COUNT);
        q = rdat;
        rd(`PWT_OFF_COUNT);
        `CHK(rdat, q)
        // ones disarm the earlier read, so the next zero write must be ignored
        wr(`PWT_OFF_STATUS, 32'h1f);
        wr(`PWT_OFF_STATUS, 32'h0);
        rd(`PWT_OFF_STATUS);
        `CHK(rdat[0], 1'b1)
        wr(`PWT_OFF_STATUS, 32'h0);
        rd(`PWT_OFF_STATUS);
        `CHK(rdat[0], 1'b0)
        $display("test stop_and_clear done");
        rd(`PWT_OFF_IRQ_REQ);
        q = rdat | 32'h80;
        wr(`PWT_OFF_IRQ_REQ, q);
        wr(`PWT_OFF_IRQ_REQ, q & ~32'h2);
        rd(`PWT_OFF_IRQ_REQ);
        `CHK(rdat, q & ~32'h2)
        c = 0;
        wt(2, 0);
        `CHK(c <= 3, 1'b1)
        wr(`PWT_OFF_IRQ_MASK, 32'hff);
        wr(`PWT_OFF_IRQ_REQ, q);
        repeat (3) @(posedge aclk);
        `CHK(ch0_interrupt, 1'b0)
        wr(`PWT_OFF_IRQ_MASK, 32'hfd);
        c = 0;
        wt(2, 1);
        `CHK(c <= 3, 1'b1)
        $display("test irq_mask_clear done");
        wr(`PWT_OFF_CTRL, 32'h0);
        wr(`PWT_OFF_IRQ_REQ, 32'h0);
        wr(`PWT_OFF_START, 32'h1);
        per();
        rd(`PWT_OFF_IRQ_REQ);
        `CHK(rdat[1], 1'b0)
        $display("test match_no_request done");
        wr(`PWT_OFF_GRC0, p + 3);
        wr(`PWT_OFF_GRC1, 32'h1);
        wr(`PWT_OFF_CTRL, 32'h3);
        per();
        per();
        `CHK(c, p + 4)
        $display("test buffer_reload done");
        wr(`PWT_OFF_START, 32'h0);
        wr(`PWT_OFF_IRQ_MASK, 32'hff);
        repeat (3) @(posedge aclk);
        `CHK(ch0_interrupt, 1'b0)
        // event path: flag a matches were recorded, enabling them raises the line
        wr(`PWT_OFF_EVT_EN, 32'h1);
        c = 0;
        wt(2, 1);
        `CHK(c <= 3, 1'b1)
        wr(`PWT_OFF_EVT, 32'h1f);
        c = 0;
        wt(2, 0);
        `CHK(c <= 3, 1'b1)
        rd(`PWT_OFF_EVT);
        `CHK(rdat, 32'h0)
        $display("test event_path done");
        end_sim();
    end
endmodule // test_pwm_timer_start_and_match_irq
bind pwt_top pwt_top_sva u_sva (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ch0_interrupt);
`default_nettype wire
